// ### src/ahs_slave.sv
`timescale 1ns/1ns
`include "ahs_defs.svh"
// Function
// - device only answers requests, never sends on its own.
// - modbus supports function codes 03h, 04h, 06h and 10h.
// - modbus exceptions 01h/02h/03h/06h; 14h for locked or read-only writes.
// - good reply: ack 06h, station, command letter, data, sum, eot.
// - bad request: nak 15h, station, command, error code, sum, eot; 9 bytes.
// - station is two uppercase hex characters, valid 01 to 1F.
// - words and addresses travel as four hex characters, high nibble first.
// - error codes are two printable characters between 20h and 7Fh.
// - receive buffer holds 39 bytes, transmit buffer 44 bytes.
// - monitor list holds up to eight word addresses.
// - sum is low byte of station, command and data characters.
// - read 'R', address, count 1-8; reply returns consecutive words.
// - write 'W', address, count, data words; reply echoes words except on the first write.
// - first write exchange returns old data, later ones current data.
// - 'X' stores up to eight addresses; seven-byte reply without data.
// - 'Y' returns all monitored values in registration order.
// - two stop bits for modbus, one for the ascii protocol.
// - protocol select 0 picks modbus, 1 the ascii protocol.
// - line speed code selectable, resets to code 3 (9600 bps).
// - report bad command, missing address, range, blocked write, frame errors.
module ahs_slave #(
   parameter int RX_DEPTH  = 39,
   parameter int TX_DEPTH  = 44,
   parameter int MON_DEPTH = 8
) (
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                sys_rst_i,
   // configuration
   input  wire logic                proto_sel_i,
   input  wire logic [2:0]          baud_code_i,
   input  wire logic                cfg_load_i,
   input  wire logic [7:0]          station_i,
   input  wire logic                write_lock_i,
   output logic      [2:0]          baud_sel_o,
   output logic                     stop_two_o,
   // received characters
   input  wire logic [7:0]          rx_data_i,
   input  wire logic                rx_valid_i,
   output logic                     rx_ready_o,
   // transmitted characters
   output logic      [7:0]          tx_data_o,
   output logic                     tx_valid_o,
   input  wire logic                tx_ready_i,
   // parameter access
   output ahs_pkg::ahs_preq_type    par_o,
   input  wire ahs_pkg::ahs_prsp_type par_i,
   // modbus request check
   input  wire ahs_pkg::ahs_mbreq_type mb_i,
   output logic      [7:0]          mb_exc_o,
   output logic                     mb_vld_o
);
   import ahs_pkg::*;

   function automatic logic hexok(input logic [7:0] c);
      hexok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction : hexok

   function automatic logic [3:0] hexn(input logic [7:0] c);
      hexn = (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
   endfunction : hexn

   function automatic logic [7:0] n2h(input logic [3:0] n);
      n2h = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction : n2h

   ahs_state_type st_reg, st_next;
   logic [7:0]    rxb_reg [RX_DEPTH];
   logic [7:0]    rxb_next [RX_DEPTH];
   logic [7:0]    txb_reg [TX_DEPTH];
   logic [7:0]    txb_next [TX_DEPTH];
   logic [15:0]   mon_reg [MON_DEPTH];
   logic [15:0]   mon_next [MON_DEPTH];
   logic [5:0]    rcnt_reg, rcnt_next, idx_reg, idx_next;
   logic [5:0]    tp_reg, tp_next, txlen_reg, txlen_next;
   logic [7:0]    sum_reg, sum_next, tsum_reg, tsum_next;
   logic [3:0]    n_reg, n_next, k_reg, k_next, mcnt_reg, mcnt_next;
   logic [15:0]   base_reg, base_next;
   logic          ovf_reg, ovf_next, first_reg, first_next;
   logic          rdy_reg, rdy_next;
   ahs_preq_type  par_reg, par_next;
   logic          push;
   logic [7:0]    ov_d_reg, ov_d_next, sk_d_reg, sk_d_next;
   logic          ov_v_reg, ov_v_next, sk_v_reg, sk_v_next;

   assign push = (st_reg == ST_TX) && !sk_v_reg;

   always_comb begin : eng
      logic [7:0]  cmd;
      logic [7:0]  stn;
      logic [3:0]  cnt;
      logic [5:0]  exp_len;
      logic [5:0]  wi;
      logic [15:0] word;
      logic [15:0] ecode;
      logic        bad;
      logic        nak;
      st_next    = st_reg;
      rxb_next   = rxb_reg;
      txb_next   = txb_reg;
      mon_next   = mon_reg;
      rcnt_next  = rcnt_reg;
      idx_next   = idx_reg;
      tp_next    = tp_reg;
      txlen_next = txlen_reg;
      sum_next   = sum_reg;
      tsum_next  = tsum_reg;
      n_next     = n_reg;
      k_next     = k_reg;
      mcnt_next  = mcnt_reg;
      base_next  = base_reg;
      ovf_next   = ovf_reg;
      first_next = first_reg;
      par_next   = par_reg;
      cmd        = rxb_reg[`AHS_POS_CMD];
      stn        = {hexn(rxb_reg[0]), hexn(rxb_reg[1])};
      cnt        = hexn(cmd == `AHS_CMD_MREG ? rxb_reg[`AHS_POS_ADDR] : rxb_reg[`AHS_POS_CNT]);
      wi         = 6'd0;
      word       = 16'h0000;
      ecode      = 16'h0000;
      bad        = 1'b0;
      nak        = 1'b0;
      exp_len    = 6'd0;
      case (cmd)
         `AHS_CMD_RD:   exp_len = `AHS_LEN_RD;
         `AHS_CMD_WR:   exp_len = `AHS_LEN_WR0 + {cnt, 2'b00};
         `AHS_CMD_MREG: exp_len = `AHS_LEN_MREG0 + {cnt, 2'b00};
         `AHS_CMD_MACT: exp_len = `AHS_LEN_MACT;
         default:       exp_len = 6'd0;
      endcase
      for (int i = 0; i < RX_DEPTH; i++) begin
         if (6'(i) < rcnt_reg && 6'(i) != `AHS_POS_CMD && !hexok(rxb_reg[i])) begin
            bad = 1'b1;
         end
      end
      case (st_reg)
         ST_IDLE: begin
            if (rx_valid_i && rdy_reg && proto_sel_i && rx_data_i == `AHS_ENQ) begin
               st_next   = ST_RX;
               rcnt_next = 6'd0;
               ovf_next  = 1'b0;
            end
         end
         ST_RX: begin
            if (rx_valid_i && rdy_reg) begin
               if (rx_data_i == `AHS_ENQ) begin
                  rcnt_next = 6'd0;
                  ovf_next  = 1'b0;
               end else if (rx_data_i == `AHS_EOT) begin
                  st_next  = (rcnt_reg < `AHS_LEN_MIN) ? ST_IDLE : ST_SUM;
                  idx_next = 6'd0;
                  sum_next = 8'h00;
               end else if (rcnt_reg < 6'(RX_DEPTH)) begin
                  rxb_next[rcnt_reg] = rx_data_i;
                  rcnt_next          = rcnt_reg + 6'd1;
               end else begin
                  ovf_next = 1'b1;
               end
            end
         end
         ST_SUM: begin
            if (idx_reg < rcnt_reg - 6'd2) begin
               sum_next = sum_reg + rxb_reg[idx_reg];
               idx_next = idx_reg + 6'd1;
            end else begin
               st_next = ST_DEC;
            end
         end
         ST_DEC: begin
            if (stn != station_i || stn == 8'h00 || stn > `AHS_STN_MAX) begin
               st_next = ST_IDLE;
            end else begin
               txb_next[0] = `AHS_ACK;
               for (int i = 1; i < 4; i++) begin
                  txb_next[i] = rxb_reg[i - 1];
               end
               tsum_next = rxb_reg[0] + rxb_reg[1] + rxb_reg[2];
               tp_next   = `AHS_POS_HDR;
               k_next    = 4'd0;
               n_next    = (cmd == `AHS_CMD_MACT) ? mcnt_reg : cnt;
               base_next = {hexn(rxb_reg[3]), hexn(rxb_reg[4]),
                            hexn(rxb_reg[5]), hexn(rxb_reg[6])};
               st_next   = ST_EXE;
               if (ovf_reg || bad ||
                   {hexn(rxb_reg[rcnt_reg - 6'd2]), hexn(rxb_reg[rcnt_reg - 6'd1])} != sum_reg) begin
                  nak   = 1'b1;
                  ecode = `AHS_E_FRAME;
               end else if (exp_len == 6'd0) begin
                  nak   = 1'b1;
                  ecode = `AHS_E_CMD;
               end else if (cmd != `AHS_CMD_MACT && (cnt == 4'd0 || cnt > `AHS_CNT_MAX)) begin
                  nak   = 1'b1;
                  ecode = `AHS_E_FRAME;
               end else if (rcnt_reg != exp_len) begin
                  nak   = 1'b1;
                  ecode = `AHS_E_FRAME;
               end
            end
         end
         ST_EXE: begin
            if (k_reg == n_reg) begin
               st_next = ST_FIN;
            end else if (cmd == `AHS_CMD_MREG) begin
               wi = `AHS_POS_MADDR + {k_reg, 2'b00};
               mon_next[k_reg[2:0]] = {hexn(rxb_reg[wi]), hexn(rxb_reg[wi + 6'd1]),
                                       hexn(rxb_reg[wi + 6'd2]), hexn(rxb_reg[wi + 6'd3])};
               k_next = k_reg + 4'd1;
            end else begin
               wi             = `AHS_POS_WDATA + {k_reg, 2'b00};
               par_next.wr    = (cmd == `AHS_CMD_WR);
               par_next.addr  = (cmd == `AHS_CMD_MACT) ? mon_reg[k_reg[2:0]]
                                                        : base_reg + {12'h000, k_reg};
               par_next.wdata = (cmd != `AHS_CMD_WR) ? 16'h0000
                              : {hexn(rxb_reg[wi]), hexn(rxb_reg[wi + 6'd1]),
                                 hexn(rxb_reg[wi + 6'd2]), hexn(rxb_reg[wi + 6'd3])};
               if (par_next.wr && write_lock_i && par_next.addr != `AHS_LOCK_ADDR) begin
                  nak   = 1'b1;
                  ecode = `AHS_E_BLOCK;
               end else begin
                  par_next.req = 1'b1;
                  st_next      = ST_ACC;
               end
            end
         end
         ST_ACC: begin
            if (par_i.ack) begin
               par_next.req = 1'b0;
               case (par_i.err)
                  PE_ADDR:  ecode = `AHS_E_ADDR;
                  PE_RANGE: ecode = `AHS_E_RANGE;
                  PE_BLOCK: ecode = `AHS_E_BLOCK;
                  default:  ecode = 16'h0000;
               endcase
               nak  = (par_i.err != PE_OK);
               word = (par_reg.wr && !first_reg) ? par_reg.wdata : par_i.rdata;
               for (int j = 0; j < 4; j++) begin
                  txb_next[tp_reg + 6'(j)] = n2h(word[15 - 4 * j -: 4]);
               end
               tsum_next = tsum_reg + n2h(word[15:12]) + n2h(word[11:8])
                           + n2h(word[7:4]) + n2h(word[3:0]);
               tp_next   = tp_reg + 6'd4;
               k_next    = k_reg + 4'd1;
               st_next   = ST_EXE;
            end
         end
         ST_FIN: begin
            txb_next[tp_reg]         = n2h(tsum_reg[7:4]);
            txb_next[tp_reg + 6'd1]  = n2h(tsum_reg[3:0]);
            txb_next[tp_reg + 6'd2]  = `AHS_EOT;
            txlen_next = tp_reg + 6'd3;
            idx_next   = 6'd0;
            st_next    = ST_TX;
            if (txb_reg[0] == `AHS_ACK && cmd == `AHS_CMD_MREG) begin
               mcnt_next = n_reg;
            end
            if (txb_reg[0] == `AHS_ACK && cmd == `AHS_CMD_WR) begin
               first_next = 1'b0;
            end
         end
         ST_TX: begin
            if (push) begin
               idx_next = idx_reg + 6'd1;
               if (idx_reg == txlen_reg - 6'd1) begin
                  st_next = ST_IDLE;
               end
            end
         end
         default: st_next = ST_IDLE;
      endcase
      if (nak) begin
         txb_next[0] = `AHS_NAK;
         txb_next[`AHS_POS_HDR]        = ecode[15:8];
         txb_next[`AHS_POS_HDR + 6'd1] = ecode[7:0];
         tsum_next = txb_next[1] + txb_next[2] + txb_next[3] + ecode[15:8] + ecode[7:0];
         tp_next   = `AHS_POS_NAKEND;
         st_next   = ST_FIN;
      end
      rdy_next = (st_next == ST_IDLE) || (st_next == ST_RX);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_reg    <= ST_IDLE;
         rcnt_reg  <= 6'd0;
         idx_reg   <= 6'd0;
         tp_reg    <= 6'd0;
         txlen_reg <= 6'd0;
         sum_reg   <= 8'h00;
         tsum_reg  <= 8'h00;
         n_reg     <= 4'd0;
         k_reg     <= 4'd0;
         mcnt_reg  <= 4'd0;
         base_reg  <= 16'h0000;
         ovf_reg   <= 1'b0;
         first_reg <= 1'b1;
         rdy_reg   <= 1'b0;
         par_reg   <= '0;
      end else begin
         st_reg    <= st_next;
         rcnt_reg  <= rcnt_next;
         idx_reg   <= idx_next;
         tp_reg    <= tp_next;
         txlen_reg <= txlen_next;
         sum_reg   <= sum_next;
         tsum_reg  <= tsum_next;
         n_reg     <= n_next;
         k_reg     <= k_next;
         mcnt_reg  <= mcnt_next;
         base_reg  <= base_next;
         ovf_reg   <= ovf_next;
         first_reg <= first_next;
         rdy_reg   <= rdy_next;
         par_reg   <= par_next;
      end
      rxb_reg <= rxb_next;
      txb_reg <= txb_next;
      mon_reg <= mon_next;
   end

   // two-entry output buffer: head register plus skid register
   always_comb begin
      ov_v_next = ov_v_reg;
      ov_d_next = ov_d_reg;
      sk_v_next = sk_v_reg;
      sk_d_next = sk_d_reg;
      if (ov_v_reg && tx_ready_i) begin
         ov_v_next = sk_v_reg;
         ov_d_next = sk_d_reg;
         sk_v_next = 1'b0;
      end
      if (push) begin
         if (!ov_v_next) begin
            ov_v_next = 1'b1;
            ov_d_next = txb_reg[idx_reg];
         end else begin
            sk_v_next = 1'b1;
            sk_d_next = txb_reg[idx_reg];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ov_v_reg <= 1'b0;
         ov_d_reg <= 8'h00;
         sk_v_reg <= 1'b0;
         sk_d_reg <= 8'h00;
      end else begin
         ov_v_reg <= ov_v_next;
         ov_d_reg <= ov_d_next;
         sk_v_reg <= sk_v_next;
         sk_d_reg <= sk_d_next;
      end
   end

   // configuration and modbus exception check
   logic [2:0] baud_reg, baud_next;
   logic       stop_reg, stop_next, mbv_reg, mbv_next;
   logic [7:0] mbx_reg, mbx_next;

   always_comb begin
      logic wr_f;
      wr_f      = (mb_i.func == `AHS_MB_WRS) || (mb_i.func == `AHS_MB_WRM);
      baud_next = cfg_load_i ? baud_code_i : baud_reg;
      stop_next = !proto_sel_i;
      mbv_next  = mb_i.vld && !proto_sel_i;
      mbx_next  = mbx_reg;
      if (mb_i.vld) begin
         if (!wr_f && mb_i.func != `AHS_MB_RDH && mb_i.func != `AHS_MB_RDI) begin
            mbx_next = `AHS_MB_X_FUNC;
         end else if (!mb_i.addr_ok) begin
            mbx_next = `AHS_MB_X_ADDR;
         end else if (!mb_i.val_ok) begin
            mbx_next = `AHS_MB_X_VAL;
         end else if (wr_f && (write_lock_i || mb_i.ro)) begin
            mbx_next = `AHS_MB_X_USER;
         end else if (mb_i.busy) begin
            mbx_next = `AHS_MB_X_BUSY;
         end else begin
            mbx_next = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         baud_reg <= `AHS_BAUD_RST;
         stop_reg <= 1'b1;
         mbv_reg  <= 1'b0;
         mbx_reg  <= 8'h00;
      end else begin
         baud_reg <= baud_next;
         stop_reg <= stop_next;
         mbv_reg  <= mbv_next;
         mbx_reg  <= mbx_next;
      end
   end

   assign baud_sel_o = baud_reg;
   assign stop_two_o = stop_reg;
   assign rx_ready_o = rdy_reg;
   assign tx_data_o  = ov_d_reg;
   assign tx_valid_o = ov_v_reg;
   assign par_o      = par_reg;
   assign mb_exc_o   = mbx_reg;
   assign mb_vld_o   = mbv_reg;
endmodule : ahs_slave

// ### src/ahs_defs.svh
`ifndef AHS_DEFS_SVH
`define AHS_DEFS_SVH
// framing control bytes
`define AHS_ENQ        8'h05
`define AHS_EOT        8'h04
`define AHS_ACK        8'h06
`define AHS_NAK        8'h15
// command letters
`define AHS_CMD_RD     8'h52
`define AHS_CMD_WR     8'h57
`define AHS_CMD_MREG   8'h58
`define AHS_CMD_MACT   8'h59
// stored request lengths, enq and eot not counted
`define AHS_LEN_MIN    6'd5
`define AHS_LEN_RD     6'd10
`define AHS_LEN_WR0    6'd10
`define AHS_LEN_MREG0  6'd6
`define AHS_LEN_MACT   6'd5
// field positions in the receive and transmit buffers
`define AHS_POS_CMD    6'd2
`define AHS_POS_ADDR   6'd3
`define AHS_POS_CNT    6'd7
`define AHS_POS_WDATA  6'd8
`define AHS_POS_MADDR  6'd4
`define AHS_POS_HDR    6'd4
`define AHS_POS_NAKEND 6'd6
// station limits and fixed values
`define AHS_STN_MAX    8'h1f
`define AHS_CNT_MAX    4'd8
`define AHS_LOCK_ADDR  16'h0004
`define AHS_BAUD_RST   3'd3
// two-character error codes
`define AHS_E_CMD      16'h4946
`define AHS_E_ADDR     16'h4941
`define AHS_E_RANGE    16'h4944
`define AHS_E_BLOCK    16'h574d
`define AHS_E_FRAME    16'h4645
// modbus function and exception codes
`define AHS_MB_RDH     8'h03
`define AHS_MB_RDI     8'h04
`define AHS_MB_WRS     8'h06
`define AHS_MB_WRM     8'h10
`define AHS_MB_X_FUNC  8'h01
`define AHS_MB_X_ADDR  8'h02
`define AHS_MB_X_VAL   8'h03
`define AHS_MB_X_BUSY  8'h06
`define AHS_MB_X_USER  8'h14
`endif

// ### src/ahs_pkg.sv
package ahs_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, ST_RX = 8'h02, ST_SUM = 8'h04, ST_DEC = 8'h08,
      ST_EXE = 8'h10, ST_ACC = 8'h20, ST_FIN = 8'h40, ST_TX = 8'h80
   } ahs_state_type;
   typedef enum logic [1:0] {
      PE_OK = 2'h0, PE_ADDR = 2'h1, PE_RANGE = 2'h2, PE_BLOCK = 2'h3
   } ahs_perr_type;
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ahs_preq_type;
   typedef struct packed {
      logic         ack;
      ahs_perr_type err;
      logic [15:0]  rdata;
   } ahs_prsp_type;
   typedef struct packed {
      logic       vld;
      logic [7:0] func;
      logic       addr_ok;
      logic       val_ok;
      logic       busy;
      logic       ro;
   } ahs_mbreq_type;
endpackage : ahs_pkg

// ### tb/ahs_slave_checker.sv
`timescale 1ns/1ns
module ahs_slave_checker
   import ahs_pkg::*;
(
   input wire logic          ref_clk_i,
   input wire logic          sys_rst_i,
   input wire logic          proto_sel_i,
   input wire logic          cfg_load_i,
   input wire logic          write_lock_i,
   input wire logic [2:0]    baud_sel_o,
   input wire logic          stop_two_o,
   input wire logic          rx_ready_o,
   input wire logic [7:0]    tx_data_o,
   input wire logic          tx_valid_o,
   input wire logic          tx_ready_i,
   input wire ahs_preq_type  par_o,
   input wire ahs_prsp_type  par_i,
   input wire ahs_mbreq_type mb_i,
   input wire logic [7:0]    mb_exc_o,
   input wire logic          mb_vld_o
);
   logic mb_ok;
   logic mb_wr;
   logic mb_go;
   assign mb_ok = mb_i.func inside {8'h03, 8'h04, 8'h06, 8'h10};
   assign mb_wr = mb_i.func inside {8'h06, 8'h10};
   assign mb_go = mb_i.vld && !proto_sel_i;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_BAUD_HOLD: assert property (!cfg_load_i |=> $stable(baud_sel_o))
      else $error("speed code moved without load");
   AST_STOP_BITS: assert property (1'b1 |=> stop_two_o == !$past(proto_sel_i))
      else $error("stop bit count does not follow protocol select");
   AST_MB_VLD: assert property (mb_go |=> mb_vld_o)
      else $error("modbus check gave no answer");
   AST_MB_ASCII: assert property (mb_i.vld && proto_sel_i |=> !mb_vld_o)
      else $error("modbus answer while ascii selected");
   AST_MB_FUNC: assert property (mb_go && !mb_ok |=> mb_exc_o == 8'h01)
      else $error("unsupported function not refused");
   AST_MB_USER: assert property (mb_go && mb_ok && mb_i.addr_ok && mb_i.val_ok && mb_wr
      && (write_lock_i || mb_i.ro) |=> mb_exc_o == 8'h14)
      else $error("blocked modbus write not refused");
   AST_MB_HOLD: assert property (!mb_i.vld |=> $stable(mb_exc_o))
      else $error("exception code moved without request");
   AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o))
      else $error("reply character dropped while stalled");
   AST_PAR_HOLD: assert property (par_o.req && !par_i.ack |=> par_o.req && $stable(par_o))
      else $error("parameter request changed before ack");
   AST_PAR_DROP: assert property (par_o.req && par_i.ack |=> !par_o.req)
      else $error("parameter request not dropped after ack");
   AST_SILENT: assert property ($rose(tx_valid_o) |-> !rx_ready_o)
      else $error("reply started while still receiving");
endmodule : ahs_slave_checker
bind ahs_slave ahs_slave_checker i_ahs_slave_checker (.ref_clk_i(ref_clk_i),
   .sys_rst_i(sys_rst_i), .proto_sel_i(proto_sel_i), .cfg_load_i(cfg_load_i),
   .write_lock_i(write_lock_i), .baud_sel_o(baud_sel_o), .stop_two_o(stop_two_o),
   .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .par_o(par_o), .par_i(par_i), .mb_i(mb_i),
   .mb_exc_o(mb_exc_o), .mb_vld_o(mb_vld_o));

// ### tb/ahs_param_model.sv
`timescale 1ns/1ns
module ahs_param_model
   import ahs_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         slow_i,
   input  wire ahs_preq_type par_i,
   output ahs_prsp_type      par_o = '0
);
   logic [15:0] mem [16];
   int          wait_cnt = 0;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
   end
   always @(posedge ref_clk_i) begin
      par_o <= '0;
      if (par_i.req && !par_o.ack) begin
         if (wait_cnt < (slow_i ? 3 : 0)) wait_cnt <= wait_cnt + 1;
         else begin
            wait_cnt <= 0;
            par_o.ack <= 1'b1;
            // old value returned on a write
            par_o.rdata <= mem[par_i.addr[3:0]];
            if (par_i.addr > 16'h000f) par_o.err <= PE_ADDR;
            else if (par_i.wr && par_i.addr < 16'h0004) par_o.err <= PE_BLOCK;
            else if (par_i.wr && par_i.wdata == 16'hffff) par_o.err <= PE_RANGE;
            else if (par_i.wr) mem[par_i.addr[3:0]] <= par_i.wdata;
         end
      end
   end
endmodule : ahs_param_model

// ### tb/ahs_slave_tb_top.sv
`timescale 1ns/1ns
module ahs_slave_tb_top;
   import ahs_pkg::*;
   logic          ref_clk, sys_rst, proto_sel, cfg_load, write_lock, stop_two;
   logic          rx_valid, rx_ready, tx_valid, tx_ready, mb_vld, slow, stall;
   logic [2:0]    baud_code, baud_sel;
   logic [7:0]    station, rx_data, tx_data, mb_exc;
   ahs_preq_type  par_req;
   ahs_prsp_type  par_rsp;
   ahs_mbreq_type mb;
   int            mismatches = 0;
   int            num_checks = 0;
   ahs_slave i_ahs_slave (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .proto_sel_i(proto_sel),
      .baud_code_i(baud_code), .cfg_load_i(cfg_load), .station_i(station),
      .write_lock_i(write_lock), .baud_sel_o(baud_sel), .stop_two_o(stop_two),
      .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .par_o(par_req), .par_i(par_rsp), .mb_i(mb), .mb_exc_o(mb_exc), .mb_vld_o(mb_vld));
   ahs_param_model i_ahs_param_model (.ref_clk_i(ref_clk), .slow_i(slow), .par_i(par_req),
      .par_o(par_rsp));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic give_up();
      mismatches++;
      print_verdict();
   endtask : give_up
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic send_byte(logic [7:0] b);
      int n;
      rx_data = b;
      rx_valid = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1) begin
         @(negedge ref_clk);
         n++;
         if (n > 500) give_up();
      end
      @(negedge ref_clk);
   endtask : send_byte
   // enq, body, sum plus adj, eot
   task automatic send_frame(string s, logic [7:0] adj);
      logic [7:0] sum;
      string      t;
      t = s.toupper();
      sum = adj;
      for (int i = 0; i < t.len(); i++) sum += t[i];
      t = $sformatf("%s%02h", t, sum);
      t = t.toupper();
      send_byte(8'h05);
      for (int i = 0; i < t.len(); i++) send_byte(t[i]);
      send_byte(8'h04);
      rx_valid = 1'b0;
   endtask : send_frame
   task automatic get_reply(output logic [7:0] q[$]);
      int n;
      q = {};
      n = 0;
      while (q.size() == 0 || q[$] !== 8'h04) begin
         @(negedge ref_clk);
         n++;
         if (n > 3000) give_up();
         tx_ready = stall ? n[1] : 1'b1;
         if (tx_valid === 1'b1 && tx_ready) q.push_back(tx_data);
      end
   endtask : get_reply
   task automatic xfer(string req, logic [7:0] adj, logic [7:0] lead, string rsp);
      logic [7:0] q[$];
      logic [7:0] sum;
      string      e;
      e = rsp.toupper();
      sum = 8'h00;
      for (int i = 0; i < e.len(); i++) sum += e[i];
      e = $sformatf("%s%02h", e, sum);
      e = e.toupper();
      send_frame(req, adj);
      get_reply(q);
      check("reply length", 16'(q.size()), 16'(e.len() + 2));
      check("reply lead", 16'(q[0]), 16'(lead));
      for (int i = 0; i < e.len(); i++) check("reply char", 16'(q[i+1]), 16'(e[i]));
   endtask : xfer
   task automatic t_config();
      check("speed after reset", 16'(baud_sel), 16'h0003);
      check("stops after reset", 16'(stop_two), 16'h0001);
      baud_code = 3'h1;
      cfg_load = 1'b1;
      @(negedge ref_clk);
      cfg_load = 1'b0;
      proto_sel = 1'b1;
      check("speed loaded", 16'(baud_sel), 16'h0001);
      @(negedge ref_clk);
      check("stops ascii", 16'(stop_two), 16'h0000);
   endtask : t_config
   task automatic t_read();
      string r;
      xfer("01R00052", 8'h00, 8'h06, "01R10051006");
      r = "01R";
      for (int i = 8; i < 16; i++) r = {r, $sformatf("%04h", 16'h1000 + i)};
      xfer("01R00088", 8'h00, 8'h06, r);
   endtask : t_read
   task automatic t_write();
      xfer("01W000611234", 8'h00, 8'h06, "01W1006");
      xfer("01W000615678", 8'h00, 8'h06, "01W5678");
      xfer("01R00061", 8'h00, 8'h06, "01R5678");
   endtask : t_write
   task automatic t_refuse();
      string rq[8] = '{"01Q", "01R02001", "01W00071FFFF", "01W00011AAAA", "01R00051",
                       "01R00059", "01R00050", "01W00071AAAA"};
      string rs[8] = '{"01QIF", "01RIA", "01WID", "01WWM", "01RFE", "01RFE", "01RFE",
                       "01WWM"};
      string w;
      for (int i = 0; i < 8; i++) begin
         write_lock = (i == 7);
         xfer(rq[i], (i == 4) ? 8'h01 : 8'h00, 8'h15, rs[i]);
      end
      write_lock = 1'b0;
      w = "01W00008";
      for (int i = 0; i < 8; i++) w = {w, "1111"};
      xfer(w, 8'h00, 8'h15, "01WFE");
   endtask : t_refuse
   task automatic t_monitor();
      string a;
      string d;
      a = "01X8";
      d = "01Y";
      for (int i = 15; i > 7; i--) begin
         a = {a, $sformatf("%04h", i)};
         d = {d, $sformatf("%04h", 16'h1000 + i)};
      end
      xfer(a, 8'h00, 8'h06, "01X");
      xfer("01Y", 8'h00, 8'h06, d);
   endtask : t_monitor
   task automatic t_foreign();
      int seen;
      seen = 0;
      send_byte(8'h41);
      send_frame("02R00051", 8'h00);
      @(negedge ref_clk);
      station = 8'h20;
      send_frame("20R00051", 8'h00);
      repeat (300) begin
         @(negedge ref_clk);
         if (tx_valid !== 1'b0) seen++;
      end
      check("silent", 16'(seen), 16'h0000);
      station = 8'h1f;
      xfer("1FR00051", 8'h00, 8'h06, "1FR1005");
   endtask : t_foreign
   task automatic t_modbus();
      logic [12:0] req[8] = '{{8'h03, 5'b11000}, {8'h04, 5'b11100}, {8'h06, 5'b11001},
         {8'h10, 5'b11010}, {8'h07, 5'b11000}, {8'h03, 5'b01000}, {8'h06, 5'b10000},
         {8'h03, 5'b11011}};
      logic [7:0]  exc[8] = '{8'h00, 8'h06, 8'h14, 8'h14, 8'h01, 8'h02, 8'h03, 8'h00};
      for (int i = 0; i < 9; i++) begin
         proto_sel = (i == 8);
         mb = {1'b1, req[i%8][12:1]};
         write_lock = req[i%8][0];
         @(negedge ref_clk);
         check("modbus answer", 16'(mb_vld), 16'(i < 8));
         if (i < 8) check("modbus exception", 16'(mb_exc), 16'(exc[i]));
      end
      write_lock = 1'b0;
      mb.vld = 1'b0;
   endtask : t_modbus
   initial begin
      sys_rst = 1'b1;
      proto_sel = 1'b0;
      baud_code = 3'h3;
      cfg_load = 1'b0;
      station = 8'h01;
      write_lock = 1'b0;
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b1;
      mb = '0;
      slow = 1'b0;
      stall = 1'b0;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      @(negedge ref_clk);
      t_config();
      slow = 1'b1;
      stall = 1'b1;
      t_read();
      slow = 1'b0;
      t_write();
      t_refuse();
      stall = 1'b0;
      t_monitor();
      t_foreign();
      t_modbus();
      print_verdict();
   end
endmodule : ahs_slave_tb_top
